// ==== inc/tws_pkg.sv ====
// two-wire serial port: register map, control layout, state codes and engine states
package tws_pkg;
  // register indices on the plain register port
  localparam logic [2:0] A_OWN = 3'h0; // own_slave_address
  localparam logic [2:0] A_DAT = 3'h1; // serial_shift_data
  localparam logic [2:0] A_CTL = 3'h2; // serial_control
  localparam logic [2:0] A_STS = 3'h3; // serial_state_code
  localparam logic [2:0] A_DIV = 3'h4; // bit_rate_divider
  // serial_control bit positions
  localparam int C_PEN = 6; // port_enable
  localparam int C_BEG = 5; // start_request
  localparam int C_FIN = 4; // stop_request
  localparam int C_SI = 3; // interrupt flag
  localparam int C_AKS = 2; // ack_assert
  localparam int C_IEN = 0; // port_irq_enable
  // own_slave_address bit 0 is general_call_enable
  localparam int OWN_GEN = 0;
  // reset values
  localparam logic [7:0] RST_OWN = 8'h00;
  localparam logic [7:0] RST_DAT = 8'h00;
  localparam logic [7:0] RST_DIV = 8'h00;
  localparam logic [4:0] RST_CODE = 5'h1F;
  // state codes, low three bits always zero
  localparam logic [7:0] SC_NONE = 8'hF8; // nothing pending
  localparam logic [7:0] SC_START = 8'h08;
  localparam logic [7:0] SC_RSTART = 8'h10;
  localparam logic [7:0] SC_AW_ACK = 8'h18;
  localparam logic [7:0] SC_AW_NACK = 8'h20;
  localparam logic [7:0] SC_TX_ACK = 8'h28;
  localparam logic [7:0] SC_TX_NACK = 8'h30;
  localparam logic [7:0] SC_ARB = 8'h38;
  localparam logic [7:0] SC_AR_ACK = 8'h40;
  localparam logic [7:0] SC_AR_NACK = 8'h48;
  localparam logic [7:0] SC_RX_ACK = 8'h50;
  localparam logic [7:0] SC_RX_NACK = 8'h58;
  localparam logic [7:0] SC_SW_ACK = 8'h60;
  localparam logic [7:0] SC_ARB_SW = 8'h68;
  localparam logic [7:0] SC_GC_ACK = 8'h70;
  localparam logic [7:0] SC_ARB_GC = 8'h78;
  localparam logic [7:0] SC_SRX_ACK = 8'h80;
  localparam logic [7:0] SC_SRX_NACK = 8'h88;
  localparam logic [7:0] SC_GRX_ACK = 8'h90;
  localparam logic [7:0] SC_GRX_NACK = 8'h98;
  localparam logic [7:0] SC_SSTOP = 8'hA0;
  localparam logic [7:0] SC_SR_ACK = 8'hA8;
  localparam logic [7:0] SC_ARB_SR = 8'hB0;
  localparam logic [7:0] SC_STX_ACK = 8'hB8;
  localparam logic [7:0] SC_STX_NACK = 8'hC0;
  // software-visible control bits
  typedef struct packed {
    logic pen;
    logic beg;
    logic fin;
    logic si;
    logic aks;
    logic ien;
  } tws_ctrl_type;
  // engine states, one-hot
  typedef enum logic [7:0] {
    S_IDLE = 8'h01,
    S_SADDR = 8'h02,
    S_SXFER = 8'h04,
    S_HOLD = 8'h08,
    S_MSTART = 8'h10,
    S_MLOW = 8'h20,
    S_MHIGH = 8'h40,
    S_MSTOP = 8'h80
  } tws_state_type;
endpackage : tws_pkg

// ==== hdl/tws_port.sv ====
// two-wire serial port engine with its register file
`timescale 1ns/1ps
`default_nettype none
// Operation
// RL1 - match upper seven own-address bits as slave
// RL2 - general call answered only when enabled
// RL3 - data writable only while flag set
// RL4 - shift bus data in while shifting out
// RL5 - data plus hidden ack bit chain
// RL6 - drive on falling, sample on rising edge
// RL7 - hardware clears stop request on stop
// RL8 - start request enters master, sends start
// RL9 - stop request: master stop, slave unaddressed
// RL10 - new code sets flag, interrupt request
// RL11 - ack_assert decides ack slot level
// RL12 - status low three bits read zero
// RL13 - all-ones code means nothing pending
// RL14 - code visible one cycle after flag
// RL15 - master bit rate clock over divider+1
// RL16 - slave follows master clock up to 400k
// RL17 - wait for free bus before mastering
// RL18 - lost arbitration falls back to slave
// RL19 - own or general call address acked
// RL20 - master transmit: address, write, data bytes
// RL21 - master receive: address, read, acked bytes
// RL22 - control bits pick next action after clear
module tws_port (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [2:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  input wire logic global_irq_enable,
  output logic irq_req,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);
  // half of one bit period, never below one cycle
  function automatic logic [7:0] tws_half(input logic [7:0] d);
    logic [7:0] h;
    h = {1'b0, d[7:1]} + {7'h00, d[0]};
    tws_half = (h == 8'h00) ? 8'h01 : h;
  endfunction : tws_half

  // pin synchronisers and filtered levels
  logic [2:0] scl_s_r, scl_s_nxt;
  logic [2:0] sda_s_r, sda_s_nxt;
  logic scl_f_r, scl_f_nxt; // filtered clock line
  logic sda_f_r, sda_f_nxt; // filtered data line

  // a change counts only once stages two and three agree
  always_comb begin
    scl_s_nxt = {scl_s_r[1:0], scl_i};
    sda_s_nxt = {sda_s_r[1:0], sda_i};
    scl_f_nxt = (scl_s_r[1] == scl_s_r[2]) ? scl_s_r[2] : scl_f_r; // see RL16
    sda_f_nxt = (sda_s_r[1] == sda_s_r[2]) ? sda_s_r[2] : sda_f_r;
  end

  // idle bus reads high
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      scl_s_r <= 3'h7;
      sda_s_r <= 3'h7;
      scl_f_r <= 1'b1;
      sda_f_r <= 1'b1;
    end else begin
      scl_s_r <= scl_s_nxt;
      sda_s_r <= sda_s_nxt;
      scl_f_r <= scl_f_nxt;
      sda_f_r <= sda_f_nxt;
    end
  end

  // bus events seen on the filtered lines
  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise = ~scl_f_r & scl_f_nxt;
  assign scl_fall = scl_f_r & ~scl_f_nxt;
  assign start_det = scl_f_r & scl_f_nxt & sda_f_r & ~sda_f_nxt;
  assign stop_det = scl_f_r & scl_f_nxt & ~sda_f_r & sda_f_nxt;

  // register file and engine state
  tws_pkg::tws_state_type st_r, st_nxt;
  tws_pkg::tws_ctrl_type ctl_r, ctl_nxt;
  logic [7:0] own_r, own_nxt; // own address, bit 0 general call
  logic [7:0] dat_r, dat_nxt; // shift data
  logic [7:0] div_r, div_nxt; // bit rate divider
  logic [4:0] code_r, code_nxt; // current state code field
  logic [7:0] sts_r, sts_nxt; // delayed status view
  logic [7:0] rdata_r, rdata_nxt;
  logic [7:0] dcnt_r, dcnt_nxt; // bit timing counter
  logic [3:0] cnt_r, cnt_nxt; // bit index within byte, 9 is done
  logic [1:0] ph_r, ph_nxt; // step in start or stop sequence
  logic ack_r, ack_nxt; // ninth link of the shift chain
  logic master_r, master_nxt;
  logic tx_r, tx_nxt; // this byte goes out
  logic first_r, first_nxt; // address byte as master
  logic rep_r, rep_nxt; // repeated start
  logic addr_r, addr_nxt; // addressed as slave
  logic gen_r, gen_nxt; // addressed by general call
  logic lost_r, lost_nxt; // arbitration lost this transfer
  logic lostd_r, lostd_nxt; // lost during a data byte
  logic ack_en_r, ack_en_nxt; // ack_assert latched at byte start
  logic nend_r, nend_nxt; // slave byte ended with nack
  logic busy_r, busy_nxt; // bus between start and stop
  logic scl_oe_r, scl_oe_nxt;
  logic sda_oe_r, sda_oe_nxt;
  logic irq_r, irq_nxt;
  logic pin_lo_r; // open-drain pins only ever pull low
  // engine helpers
  logic post;
  logic [7:0] pcode;
  logic tdone, match, gmatch;

  // next-state logic for registers and the byte engine
  always_comb begin
    st_nxt = st_r;
    ctl_nxt = ctl_r;
    own_nxt = own_r;
    dat_nxt = dat_r;
    div_nxt = div_r;
    code_nxt = code_r;
    dcnt_nxt = dcnt_r + 8'h01;
    cnt_nxt = cnt_r;
    ph_nxt = ph_r;
    ack_nxt = ack_r;
    master_nxt = master_r;
    tx_nxt = tx_r;
    first_nxt = first_r;
    rep_nxt = rep_r;
    addr_nxt = addr_r;
    gen_nxt = gen_r;
    lost_nxt = lost_r;
    lostd_nxt = lostd_r;
    ack_en_nxt = ack_en_r;
    nend_nxt = nend_r;
    busy_nxt = busy_r;
    scl_oe_nxt = scl_oe_r;
    sda_oe_nxt = sda_oe_r;
    post = 1'b0;
    pcode = tws_pkg::SC_NONE;
    tdone = (dcnt_r >= tws_half(div_r) - 8'h01); // see RL15
    gmatch = (dat_r[7:1] == 7'h00) & own_r[tws_pkg::OWN_GEN]; // see RL2
    match = ((dat_r[7:1] == own_r[7:1]) | gmatch) & ~lostd_r; // see RL1
    // bus monitor
    if (start_det) begin
      busy_nxt = 1'b1;
    end else if (stop_det) begin
      busy_nxt = 1'b0;
    end
    // hardware clears stop request on a stop
    if (stop_det) begin
      ctl_nxt.fin = 1'b0; // see RL7
    end
    // software writes, address decode
    if (bus_wr) begin
      if (bus_addr == tws_pkg::A_OWN) begin
        own_nxt = bus_wdata;
      end else if (bus_addr == tws_pkg::A_DAT) begin
        if (ctl_r.si) begin
          dat_nxt = bus_wdata; // see RL3
        end
      end else if (bus_addr == tws_pkg::A_CTL) begin
        ctl_nxt.pen = bus_wdata[tws_pkg::C_PEN];
        ctl_nxt.beg = bus_wdata[tws_pkg::C_BEG];
        ctl_nxt.fin = bus_wdata[tws_pkg::C_FIN];
        ctl_nxt.aks = bus_wdata[tws_pkg::C_AKS];
        ctl_nxt.ien = bus_wdata[tws_pkg::C_IEN];
        // the flag can only be cleared by software
        if (!bus_wdata[tws_pkg::C_SI]) begin
          ctl_nxt.si = 1'b0;
        end
      end else if (bus_addr == tws_pkg::A_DIV) begin
        div_nxt = bus_wdata;
      end
    end
    // shift chain: sample on rising edges only
    if (st_r == tws_pkg::S_SADDR || st_r == tws_pkg::S_SXFER ||
        st_r == tws_pkg::S_MLOW || st_r == tws_pkg::S_MHIGH) begin
      if (scl_rise && cnt_r < 4'h8) begin
        dat_nxt = {dat_r[6:0], sda_f_r}; // see RL4, RL5, RL6
        cnt_nxt = cnt_r + 4'h1;
        // released a one but the line reads zero
        if (master_r && (tx_r || first_r) && !sda_oe_r && !sda_f_r) begin
          master_nxt = 1'b0; // see RL18
          lost_nxt = 1'b1;
          lostd_nxt = ~first_r;
          scl_oe_nxt = 1'b0;
          st_nxt = tws_pkg::S_SADDR;
        end
      end else if (scl_rise && cnt_r == 4'h8) begin
        ack_nxt = sda_f_r; // see RL5
        cnt_nxt = 4'h9;
      end else if (scl_fall && cnt_r != 4'h0 && cnt_r < 4'h8) begin
        sda_oe_nxt = (tx_r || first_r) & ~dat_r[7]; // see RL6
      end else if (scl_fall && cnt_r == 4'h8) begin
        // ack slot: receiver drives, transmitter lets go
        if (st_r == tws_pkg::S_SADDR) begin
          addr_nxt = match & ctl_r.aks; // see RL19
          gen_nxt = gmatch;
          sda_oe_nxt = match & ctl_r.aks; // see RL11
        end else begin
          sda_oe_nxt = ~(tx_r || first_r) & ack_en_r; // see RL11, RL21
        end
      end
    end
    case (st_r)
      tws_pkg::S_IDLE: begin
        scl_oe_nxt = 1'b0;
        sda_oe_nxt = 1'b0;
        master_nxt = 1'b0;
        if (start_det) begin
          st_nxt = tws_pkg::S_SADDR;
          cnt_nxt = 4'h0;
          lost_nxt = 1'b0;
          lostd_nxt = 1'b0;
        end else if (ctl_r.beg && !busy_r && !ctl_r.si) begin
          // nobody on the bus, safe to take it
          master_nxt = 1'b1; // see RL8, RL17
          rep_nxt = 1'b0;
          ph_nxt = 2'h0;
          dcnt_nxt = 8'h00;
          st_nxt = tws_pkg::S_MSTART;
        end
      end
      tws_pkg::S_SADDR: begin
        if (stop_det) begin
          st_nxt = tws_pkg::S_IDLE;
        end else if (start_det) begin
          cnt_nxt = 4'h0;
        end else if (scl_fall && cnt_r == 4'h9) begin
          sda_oe_nxt = 1'b0;
          if (addr_r) begin
            post = 1'b1; // see RL19
            tx_nxt = dat_r[0];
            nend_nxt = 1'b0;
            scl_oe_nxt = 1'b1;
            st_nxt = tws_pkg::S_HOLD;
            if (gen_r) begin
              pcode = lost_r ? tws_pkg::SC_ARB_GC : tws_pkg::SC_GC_ACK;
            end else if (dat_r[0]) begin
              pcode = lost_r ? tws_pkg::SC_ARB_SR : tws_pkg::SC_SR_ACK;
            end else begin
              pcode = lost_r ? tws_pkg::SC_ARB_SW : tws_pkg::SC_SW_ACK;
            end
          end else begin
            post = lost_r; // see RL18
            pcode = tws_pkg::SC_ARB;
            st_nxt = tws_pkg::S_IDLE;
          end
        end
      end
      tws_pkg::S_SXFER: begin
        if (start_det || stop_det) begin
          // master ended the transfer under us
          post = 1'b1;
          pcode = tws_pkg::SC_SSTOP;
          addr_nxt = 1'b0;
          sda_oe_nxt = 1'b0;
          cnt_nxt = 4'h0;
          lost_nxt = 1'b0;
          lostd_nxt = 1'b0;
          st_nxt = start_det ? tws_pkg::S_SADDR : tws_pkg::S_IDLE;
        end else if (scl_fall && cnt_r == 4'h9) begin
          post = 1'b1;
          sda_oe_nxt = 1'b0;
          scl_oe_nxt = 1'b1; // stretch until software answers
          st_nxt = tws_pkg::S_HOLD;
          if (tx_r) begin
            pcode = ack_r ? tws_pkg::SC_STX_NACK : tws_pkg::SC_STX_ACK;
            nend_nxt = ack_r;
          end else if (gen_r) begin
            pcode = ack_en_r ? tws_pkg::SC_GRX_ACK : tws_pkg::SC_GRX_NACK;
            nend_nxt = ~ack_en_r;
          end else begin
            pcode = ack_en_r ? tws_pkg::SC_SRX_ACK : tws_pkg::SC_SRX_NACK;
            nend_nxt = ~ack_en_r;
          end
        end
      end
      tws_pkg::S_HOLD: begin
        // clock held low while the flag is up
        if (!ctl_r.si) begin
          cnt_nxt = 4'h0;
          dcnt_nxt = 8'h00;
          ph_nxt = 2'h0;
          ack_en_nxt = ctl_r.aks; // see RL22
          if (master_r) begin
            if (ctl_r.fin) begin
              st_nxt = tws_pkg::S_MSTOP; // see RL9
            end else if (ctl_r.beg) begin
              rep_nxt = 1'b1; // see RL8
              st_nxt = tws_pkg::S_MSTART;
            end else begin
              sda_oe_nxt = (tx_r || first_r) & ~dat_r[7]; // see RL20, RL21
              st_nxt = tws_pkg::S_MLOW;
            end
          end else if (ctl_r.fin || nend_r) begin
            addr_nxt = 1'b0; // see RL9
            scl_oe_nxt = 1'b0;
            sda_oe_nxt = 1'b0;
            st_nxt = tws_pkg::S_IDLE;
          end else begin
            sda_oe_nxt = tx_r & ~dat_r[7];
            scl_oe_nxt = 1'b0;
            st_nxt = tws_pkg::S_SXFER;
          end
        end
      end
      tws_pkg::S_MSTART: begin
        if (start_det && !rep_r && ph_r != 2'h2 && ph_r != 2'h3) begin
          // another master won the race for the free bus
          master_nxt = 1'b0; // see RL17
          cnt_nxt = 4'h0;
          st_nxt = tws_pkg::S_SADDR;
        end else begin
          case (ph_r)
            2'h0: begin
              sda_oe_nxt = 1'b0;
              if (tdone) begin
                ph_nxt = 2'h1;
                dcnt_nxt = 8'h00;
              end
            end
            2'h1: begin
              scl_oe_nxt = 1'b0;
              if (!scl_f_r) begin
                dcnt_nxt = 8'h00;
              end else if (tdone) begin
                ph_nxt = 2'h2;
                dcnt_nxt = 8'h00;
              end
            end
            2'h2: begin
              sda_oe_nxt = 1'b1; // data falls while clock high
              if (tdone) begin
                ph_nxt = 2'h3;
              end
            end
            default: begin
              scl_oe_nxt = 1'b1;
              if (!scl_f_r) begin
                post = 1'b1;
                pcode = rep_r ? tws_pkg::SC_RSTART : tws_pkg::SC_START;
                first_nxt = 1'b1;
                tx_nxt = 1'b1;
                st_nxt = tws_pkg::S_HOLD;
              end
            end
          endcase
        end
      end
      tws_pkg::S_MLOW: begin
        scl_oe_nxt = 1'b1;
        if (scl_fall && cnt_r == 4'h9) begin
          post = 1'b1;
          sda_oe_nxt = 1'b0;
          st_nxt = tws_pkg::S_HOLD;
          if (first_r) begin
            first_nxt = 1'b0;
            tx_nxt = ~dat_r[0];
            if (dat_r[0]) begin
              pcode = ack_r ? tws_pkg::SC_AR_NACK : tws_pkg::SC_AR_ACK; // see RL21
            end else begin
              pcode = ack_r ? tws_pkg::SC_AW_NACK : tws_pkg::SC_AW_ACK; // see RL20
            end
          end else if (tx_r) begin
            pcode = ack_r ? tws_pkg::SC_TX_NACK : tws_pkg::SC_TX_ACK; // see RL20
          end else begin
            pcode = ack_en_r ? tws_pkg::SC_RX_ACK : tws_pkg::SC_RX_NACK; // see RL21
          end
        end else if (tdone && !scl_f_r) begin
          // low half over and the fall already seen
          scl_oe_nxt = 1'b0; // see RL15
          dcnt_nxt = 8'h00;
          st_nxt = tws_pkg::S_MHIGH;
        end
      end
      tws_pkg::S_MHIGH: begin
        // a slave holding the clock low stretches this half
        if (!scl_f_r) begin
          dcnt_nxt = 8'h00;
        end else if (tdone) begin
          scl_oe_nxt = 1'b1; // see RL15
          dcnt_nxt = 8'h00;
          st_nxt = tws_pkg::S_MLOW;
        end
      end
      default: begin
        // stop: data low, clock up, then data up
        case (ph_r)
          2'h0: begin
            sda_oe_nxt = 1'b1;
            if (tdone) begin
              ph_nxt = 2'h1;
              dcnt_nxt = 8'h00;
            end
          end
          2'h1: begin
            scl_oe_nxt = 1'b0;
            if (!scl_f_r) begin
              dcnt_nxt = 8'h00;
            end else if (tdone) begin
              ph_nxt = 2'h2;
            end
          end
          default: begin
            sda_oe_nxt = 1'b0; // see RL9
            if (stop_det) begin
              master_nxt = 1'b0;
              st_nxt = tws_pkg::S_IDLE;
            end
          end
        endcase
      end
    endcase
    // a new code sets the flag; set beats a same-cycle clear
    if (post) begin
      code_nxt = pcode[7:3]; // see RL12
      ctl_nxt.si = 1'b1; // see RL10, RL22
    end
    // status view trails the flag by one cycle
    sts_nxt = ctl_r.si ? {code_r, 3'h0} : tws_pkg::SC_NONE; // see RL13, RL14
    irq_nxt = ctl_r.si & ctl_r.ien & global_irq_enable; // see RL10
    // port disabled: idle, pins released, stop request dropped
    if (!ctl_r.pen) begin
      st_nxt = tws_pkg::S_IDLE;
      master_nxt = 1'b0;
      addr_nxt = 1'b0;
      scl_oe_nxt = 1'b0;
      sda_oe_nxt = 1'b0;
    end
    if (!ctl_nxt.pen) begin
      ctl_nxt.fin = 1'b0; // see RL7
    end
    // register read, data one cycle later
    rdata_nxt = 8'h00;
    if (bus_rd) begin
      if (bus_addr == tws_pkg::A_OWN) begin
        rdata_nxt = own_r;
      end else if (bus_addr == tws_pkg::A_DAT) begin
        rdata_nxt = dat_r;
      end else if (bus_addr == tws_pkg::A_CTL) begin
        rdata_nxt = {1'b0, ctl_r.pen, ctl_r.beg, ctl_r.fin, ctl_r.si, ctl_r.aks,
                     1'b0, ctl_r.ien};
      end else if (bus_addr == tws_pkg::A_STS) begin
        rdata_nxt = sts_r;
      end else if (bus_addr == tws_pkg::A_DIV) begin
        rdata_nxt = div_r;
      end
    end
  end

  // register everything
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r <= tws_pkg::S_IDLE;
      ctl_r <= '0;
      own_r <= tws_pkg::RST_OWN;
      dat_r <= tws_pkg::RST_DAT;
      div_r <= tws_pkg::RST_DIV;
      code_r <= tws_pkg::RST_CODE;
      sts_r <= tws_pkg::SC_NONE;
      rdata_r <= 8'h00;
      dcnt_r <= 8'h00;
      cnt_r <= 4'h0;
      ph_r <= 2'h0;
      ack_r <= 1'b1;
      master_r <= 1'b0;
      tx_r <= 1'b0;
      first_r <= 1'b0;
      rep_r <= 1'b0;
      addr_r <= 1'b0;
      gen_r <= 1'b0;
      lost_r <= 1'b0;
      lostd_r <= 1'b0;
      ack_en_r <= 1'b0;
      nend_r <= 1'b0;
      busy_r <= 1'b0;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      irq_r <= 1'b0;
      pin_lo_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      ctl_r <= ctl_nxt;
      own_r <= own_nxt;
      dat_r <= dat_nxt;
      div_r <= div_nxt;
      code_r <= code_nxt;
      sts_r <= sts_nxt;
      rdata_r <= rdata_nxt;
      dcnt_r <= dcnt_nxt;
      cnt_r <= cnt_nxt;
      ph_r <= ph_nxt;
      ack_r <= ack_nxt;
      master_r <= master_nxt;
      tx_r <= tx_nxt;
      first_r <= first_nxt;
      rep_r <= rep_nxt;
      addr_r <= addr_nxt;
      gen_r <= gen_nxt;
      lost_r <= lost_nxt;
      lostd_r <= lostd_nxt;
      ack_en_r <= ack_en_nxt;
      nend_r <= nend_nxt;
      busy_r <= busy_nxt;
      scl_oe_r <= scl_oe_nxt;
      sda_oe_r <= sda_oe_nxt;
      irq_r <= irq_nxt;
      pin_lo_r <= 1'b0;
    end
  end

  // slave timing: 3-cycle filter at 10 MHz fits 400 kHz high and low times
  assign bus_rdata = rdata_r;
  assign irq_req = irq_r;
  assign scl_oe = scl_oe_r;
  assign sda_oe = sda_oe_r;
  assign scl_o = pin_lo_r;
  assign sda_o = pin_lo_r;
endmodule : tws_port
`default_nettype wire

// ==== tb/tws_asserts.sv ====
// checker: port-level properties of the two-wire serial port
`timescale 1ns/1ps
`default_nettype none
module tws_asserts (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [2:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_rdata,
  input wire logic global_irq_enable,
  input wire logic irq_req,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe
);
  logic ien_r, pen_r; // shadow of written control bits
  logic ctl_wr; // control write this cycle
  assign ctl_wr = bus_wr && bus_addr == tws_pkg::A_CTL;
  // shadow follows software writes only
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ien_r <= 1'b0;
      pen_r <= 1'b0;
    end else if (ctl_wr) begin
      ien_r <= bus_wdata[tws_pkg::C_IEN];
      pen_r <= bus_wdata[tws_pkg::C_PEN];
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_rdata_idle: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
    else $error("read data not zero");
  a_status_low: assert property ($past(bus_rd) && $past(bus_addr) == tws_pkg::A_STS
    |-> bus_rdata[2:0] == 3'h0) else $error("status low bits set");
  a_stop_enable: assert property ($past(bus_rd) && $past(bus_addr) == tws_pkg::A_CTL
    && bus_rdata[tws_pkg::C_FIN] |-> bus_rdata[tws_pkg::C_PEN]) else $error("stop kept");
  a_irq_cause: assert property (irq_req |-> $past(ien_r) && $past(global_irq_enable))
    else $error("irq without enables");
  a_code_pend: assert property ($past(bus_rd) && $past(bus_addr) == tws_pkg::A_STS
    && $past(irq_req) |-> bus_rdata != tws_pkg::SC_NONE) else $error("no code");
  a_pins_low: assert property (!scl_o && !sda_o) else $error("pin driven high");
  a_off_quiet: assert property (!pen_r && !$past(pen_r) |-> !scl_oe && !sda_oe)
    else $error("disabled port drives");
  a_ien_off: assert property (ctl_wr && !bus_wdata[tws_pkg::C_IEN] ##1 !ctl_wr
    |=> !irq_req) else $error("irq not masked");
endmodule : tws_asserts
bind tws_port tws_asserts u_chk (.clk_sys, .rst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
  .bus_rdata, .global_irq_enable, .irq_req, .scl_i, .scl_o, .scl_oe, .sda_i, .sda_o, .sda_oe);
`default_nettype wire

// ==== tb/tws_slave_model.sv ====
// partner: behavioural target on the two-wire bus
`timescale 1ns/1ps
`default_nettype none
module tws_slave_model #(parameter logic [6:0] SLV = 7'h2C) (
  input wire logic scl,
  input wire logic sda,
  output logic pull
);
  int pos; // slot in byte, 9 is ack
  logic act, adr, sel, rd; // framed, address phase, matched, read
  logic [7:0] sh, txb; // shift in, next byte out
  logic [7:0] got[$]; // bytes written to us
  initial begin
    pull = 0;
    act = 0;
    txb = 8'hA5;
  end
  // start or repeated start opens an address phase
  always @(negedge sda) if (scl) begin
    act = 1;
    adr = 1;
    sel = 0;
    pos = 0;
  end
  always @(posedge sda) if (scl) act = 0; // stop
  // sample on rising clock; a nack ends our sending
  always @(posedge scl) if (act) begin
    if (pos > 0 && pos < 9) sh = {sh[6:0], sda};
    else if (pos == 9 && rd && sda) sel = 0;
  end
  // change the line only after falling clock
  always @(negedge scl) if (act) begin
    pos = pos % 9 + 1;
    pull = 0;
    if (pos == 9 && adr) begin
      adr = 0;
      sel = (sh[7:1] == SLV);
      rd = sh[0];
      pull = sel;
    end else if (pos == 9 && sel && !rd) begin
      got.push_back(sh);
      pull = 1;
    end else if (pos == 9 && sel) txb = txb + 8'h11;
    else if (sel && rd) pull = !txb[8 - pos];
  end
endmodule : tws_slave_model
`default_nettype wire

// ==== tb/two_wire_serial_port_test.sv ====
// testbench: register port and master transfers against a bus target
`timescale 1ns/1ps
`default_nettype none
module two_wire_serial_port_test;
  localparam logic [6:0] SLV = 7'h2C; // target address
  logic clk_sys = 0, rst = 1, bus_wr = 0, bus_rd = 0, global_irq_enable = 1;
  logic [2:0] bus_addr = 0;
  logic [7:0] bus_wdata = 0, bus_rdata, rdv, b;
  logic irq_req, scl_o, scl_oe, sda_o, sda_oe, pull, scl, sda;
  int fail_count = 0, checks = 0, cyc = 0;
  logic [31:0] seed = 32'h27CE207E;
  assign scl = !scl_oe; // pull-up lines
  assign sda = !(sda_oe || pull);
  always #50 clk_sys = !clk_sys;
  tws_port dut_u (.clk_sys, .rst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
    .global_irq_enable, .irq_req, .scl_i(scl), .scl_o, .scl_oe, .sda_i(sda), .sda_o, .sda_oe);
  tws_slave_model #(.SLV(SLV)) peer_u (.scl, .sda, .pull);
  function automatic logic [7:0] rnd;
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd
  task final_report;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one strobe cycle; read data caught in the cycle after
  task op(input logic r, input logic [2:0] a, input logic [7:0] d);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= !r;
    bus_rd <= r;
    @(posedge clk_sys);
    #1 rdv = bus_rdata;
  endtask : op
  task rd(input string nm, input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    op(1, a, 8'h00);
    chk(nm, rdv & m, e);
  endtask : rd
  task code(input logic [7:0] e);
    rd("state code", tws_pkg::A_STS, 8'hFF, e);
  endtask : code
  // bus idle, then bounded wait for the interrupt request
  task await;
    int n;
    bus_wr <= 0;
    bus_rd <= 0;
    for (n = 0; n < 4000 && (n < 3 || irq_req !== 1'b1); n++) @(posedge clk_sys) #1;
    if (n == 4000) chk("irq wait", 8'h00, 8'h01);
  endtask : await
  // ask for stop, poll until hardware drops the request
  task stop;
    int n;
    op(0, tws_pkg::A_CTL, 8'h51);
    n = 0;
    do op(1, tws_pkg::A_CTL, 8'h00); while (rdv[4] !== 1'b0 && ++n < 400);
    chk("stop done", rdv & 8'h58, 8'h40);
  endtask : stop
  always @(posedge clk_sys) if (++cyc == 60000) begin
    chk("timeout", 8'h00, 8'h01);
    final_report;
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 0;
    for (int i = 0; i < 6; i++) rd("reset", 3'(i), 8'h7D, i == 3 ? 8'h78 : 8'h00);
    b = rnd();
    op(0, tws_pkg::A_OWN, b);
    rd("own", tws_pkg::A_OWN, 8'hFF, b);
    op(0, tws_pkg::A_DAT, rnd());
    rd("data locked", tws_pkg::A_DAT, 8'hFF, 8'h00);
    op(0, tws_pkg::A_CTL, 8'h18);
    rd("control", tws_pkg::A_CTL, 8'h7D, 8'h00);
    op(0, tws_pkg::A_STS, 8'h55);
    code(tws_pkg::SC_NONE);
    op(0, tws_pkg::A_DIV, 8'h03);
    rd("divider", tws_pkg::A_DIV, 8'hFF, 8'h03);
    op(0, tws_pkg::A_CTL, 8'h61);
    await;
    code(tws_pkg::SC_START);
    global_irq_enable <= 0;
    repeat (3) @(posedge clk_sys) #1;
    chk("masked irq", {7'h00, irq_req}, 8'h00);
    global_irq_enable <= 1;
    op(0, tws_pkg::A_DAT, {SLV, 1'b0});
    op(0, tws_pkg::A_CTL, 8'h41);
    await;
    code(tws_pkg::SC_AW_ACK);
    b = rnd();
    op(0, tws_pkg::A_DAT, b);
    op(0, tws_pkg::A_CTL, 8'h41);
    code(tws_pkg::SC_AW_ACK);
    code(tws_pkg::SC_NONE);
    await;
    code(tws_pkg::SC_TX_ACK);
    chk("target byte", peer_u.got[0], b);
    rd("data kept", tws_pkg::A_DAT, 8'hFF, b);
    stop;
    op(0, tws_pkg::A_CTL, 8'h61);
    await;
    op(0, tws_pkg::A_DAT, {SLV, 1'b1});
    op(0, tws_pkg::A_CTL, 8'h45);
    await;
    code(tws_pkg::SC_AR_ACK);
    op(0, tws_pkg::A_CTL, 8'h45);
    await;
    code(tws_pkg::SC_RX_ACK);
    rd("rx byte", tws_pkg::A_DAT, 8'hFF, 8'hA5);
    op(0, tws_pkg::A_CTL, 8'h41);
    await;
    code(tws_pkg::SC_RX_NACK);
    rd("rx byte", tws_pkg::A_DAT, 8'hFF, 8'hB6);
    stop;
    op(0, tws_pkg::A_CTL, 8'h61);
    await;
    op(0, tws_pkg::A_DAT, {SLV ^ 7'h01, 1'b0});
    op(0, tws_pkg::A_CTL, 8'h41);
    await;
    code(tws_pkg::SC_AW_NACK);
    stop;
    final_report;
  end
endmodule : two_wire_serial_port_test
`default_nettype wire
